// [inc/dlr_pkg.sv]
package dlr_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [3:0] CTRL_ADDR = 4'h0;     // Enable, mode, taps, depth
  localparam logic [3:0] FVLEN_ADDR = 4'h4;    // Frame valid length in lines
  localparam logic [3:0] LINELEN_ADDR = 4'h8;  // Region of interest width
  localparam logic [3:0] STATUS_ADDR = 4'hc;   // Sequencer state, read only

  // ************************************************************
  // Field positions of the control register
  // ************************************************************
  localparam int CTRL_EN_BIT = 0;      // Paired mode enable
  localparam int CTRL_MODE_BIT = 1;    // 0 line A leads, 1 line B leads
  localparam int CTRL_TAP_LSB = 2;     // 2 bits: 0=2, 1=4, 2=8 taps
  localparam int CTRL_DEPTH_LSB = 4;   // 2 bits: 0=8, 1=10, 2=12 bits

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] FVLEN_RST = 16'h0000;
  localparam logic [13:0] LINELEN_RST = 14'h0000;  // Zero means full width

  // ************************************************************
  // Counts
  // ************************************************************
  localparam int PIX_W = 12;           // Widest pixel on the wire
  localparam int MAX_TAPS = 8;         // Widest tap mode
  localparam int FULL_PIX = 8192;      // Widest sensor line
  localparam int NARROW_MAX = 4096;    // Widest sensor for B leading
  localparam int SYNC_STAGES = 2;      // Trigger synchroniser depth

  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_EXPOSE, ST_REPLAY} dlr_state_type;

endpackage : dlr_pkg

// [rtl/dlr_readout.sv]
// How it works
// RL1 - Two, four or eight taps; 8/10/12 bits
// RL2 - Frame valid rises on the leading line
// RL3 - Frame valid length even; drops after count
// RL4 - Length zero keeps frame valid low
// RL5 - Each line carries N pixels
// RL6 - Marker bit places fixed in all modes
// RL7 - B leading swaps lines; narrow sensors only
// RL8 - Odd triggers expose and read both lines
// RL9 - Exposure sends leading line, buffers other
// RL10 - Even triggers send buffered line, no exposure
// RL11 - Buffered line leaves three triggers later
// RL12 - Leading and following lines image same area
// RL13 - First pair after enable is junk, unmarked
// RL14 - Grabber gives two triggers per exposure
// RL15 - Pixel order kept from pixel one
// RL16 - Line and data valid span the pixels
`timescale 1ns/1ps
`default_nettype none

module dlr_readout #(
  parameter int SENSOR_PIX = dlr_pkg::FULL_PIX,  // Sensor line width
  parameter int PIX_W = dlr_pkg::PIX_W,
  parameter int MAX_TAPS = dlr_pkg::MAX_TAPS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic line_trigger,
  input wire logic sens_valid,
  input wire logic [PIX_W-1:0] sens_pix_a,
  input wire logic [PIX_W-1:0] sens_pix_b,
  output logic expose_start,
  output logic fval,
  output logic lval,
  output logic dval,
  output logic pix_clk,
  output logic [MAX_TAPS*PIX_W-1:0] video
);

  localparam int IDX_W = $clog2(SENSOR_PIX);
  localparam bit MODE_B_OK = SENSOR_PIX <= dlr_pkg::NARROW_MAX;

  // ************************************************************
  // Register file
  // ************************************************************
  logic en_q;                       // Paired mode enabled
  logic mode_b_q;                   // Line B leads
  logic [1:0] tap_q;                // Tap mode
  logic [1:0] depth_q;              // Bit depth
  logic [15:0] fval_len_q;          // Frame valid length, always even
  logic [13:0] line_len_q;          // Region of interest width
  logic [31:0] rdata_d;

  wire wr_ctrl = reg_wr && reg_addr == dlr_pkg::CTRL_ADDR;
  wire wr_fvlen = reg_wr && reg_addr == dlr_pkg::FVLEN_ADDR;
  wire wr_linelen = reg_wr && reg_addr == dlr_pkg::LINELEN_ADDR;
  wire [1:0] wr_tap = reg_wdata[dlr_pkg::CTRL_TAP_LSB +: 2];
  wire [1:0] wr_depth = reg_wdata[dlr_pkg::CTRL_DEPTH_LSB +: 2];

  // Software writes; illegal encodings of taps and depth are not taken
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      en_q <= dlr_pkg::CTRL_RST[dlr_pkg::CTRL_EN_BIT];
      mode_b_q <= dlr_pkg::CTRL_RST[dlr_pkg::CTRL_MODE_BIT];
      tap_q <= dlr_pkg::CTRL_RST[dlr_pkg::CTRL_TAP_LSB +: 2];
      depth_q <= dlr_pkg::CTRL_RST[dlr_pkg::CTRL_DEPTH_LSB +: 2];
      fval_len_q <= dlr_pkg::FVLEN_RST;
      line_len_q <= dlr_pkg::LINELEN_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        en_q <= reg_wdata[dlr_pkg::CTRL_EN_BIT];
        // B leading only exists on the narrow sensors
        mode_b_q <= reg_wdata[dlr_pkg::CTRL_MODE_BIT] && MODE_B_OK;  // RL7
        if (wr_tap != 2'h3)
          tap_q <= wr_tap;                 // RL1
        if (wr_depth != 2'h3)
          depth_q <= wr_depth;             // RL1
      end
      if (wr_fvlen)
        fval_len_q <= {reg_wdata[15:1], 1'b0};  // RL3
      if (wr_linelen)
        line_len_q <= reg_wdata[13:0];
    end
  end

  // ************************************************************
  // Trigger synchroniser and edge finder
  // ************************************************************
  logic [dlr_pkg::SYNC_STAGES-1:0] trig_sync_q;  // Stage 0 feeds stage 1 only
  logic trig_old_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      trig_sync_q <= '0;
      trig_old_q <= 1'b0;
    end
    else
    begin
      trig_sync_q <= {trig_sync_q[0], line_trigger};
      trig_old_q <= trig_sync_q[1];
    end
  end

  wire trig_rise = trig_sync_q[1] && !trig_old_q;

  // ************************************************************
  // Sequencer
  // ************************************************************
  dlr_pkg::dlr_state_type st_q;
  logic phase_q;                    // 0: next trigger exposes, 1: replays
  logic wr_bank_q;                  // Bank written by the last exposure
  logic rd_bank_q;                  // Bank being replayed
  logic [IDX_W-1:0] idx_q;          // Pixel index within the line
  logic lead_q;                     // Current line is the leading one
  logic en_old_q;
  logic rd_vld_q;                   // Buffer read data valid this cycle
  logic rd_last_q;

  // Zero width or too wide means the whole sensor line
  wire roi_on = line_len_q != 14'h0 && 32'(line_len_q) <= SENSOR_PIX;
  wire [IDX_W-1:0] last_idx = roi_on ? IDX_W'(line_len_q - 14'h1)
                                     : IDX_W'(SENSOR_PIX - 1);  // RL5
  wire accept = en_q && trig_rise && st_q == dlr_pkg::ST_IDLE;
  wire at_last = idx_q == last_idx;
  wire en_rise = en_q && !en_old_q;

  // Odd triggers expose, even ones replay; a trigger during a line is
  // dropped, since the grabber must pace two triggers per exposure
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= dlr_pkg::ST_IDLE;
      phase_q <= 1'b0;
      wr_bank_q <= 1'b0;
      rd_bank_q <= 1'b0;
      idx_q <= '0;
      lead_q <= 1'b0;
      en_old_q <= 1'b0;
      expose_start <= 1'b0;
    end
    else
    begin
      en_old_q <= en_q;
      expose_start <= 1'b0;
      if (en_rise)
        phase_q <= 1'b0;                   // RL13
      case (st_q)
        dlr_pkg::ST_IDLE:
        begin
          idx_q <= '0;
          if (accept && !phase_q)
          begin
            expose_start <= 1'b1;          // RL8
            wr_bank_q <= !wr_bank_q;       // RL11
            lead_q <= 1'b1;
            phase_q <= 1'b1;               // RL14
            st_q <= dlr_pkg::ST_EXPOSE;
          end
          else if (accept)
          begin
            // Other bank holds the exposure before last
            rd_bank_q <= !wr_bank_q;       // RL11
            lead_q <= 1'b0;                // RL10
            phase_q <= 1'b0;
            st_q <= dlr_pkg::ST_REPLAY;
          end
        end
        dlr_pkg::ST_EXPOSE:
        begin
          if (sens_valid)
            idx_q <= at_last ? '0 : idx_q + 1'b1;
          if (sens_valid && at_last)
            st_q <= dlr_pkg::ST_IDLE;
        end
        dlr_pkg::ST_REPLAY:
        begin
          idx_q <= at_last ? '0 : idx_q + 1'b1;
          if (at_last)
            st_q <= dlr_pkg::ST_IDLE;
        end
        default:
          st_q <= dlr_pkg::ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Line buffer, two banks so a held line survives the next exposure
  // ************************************************************
  logic [PIX_W-1:0] buf_mem [2*SENSOR_PIX];
  logic [PIX_W-1:0] rd_pix_q;

  // Sensor order is kept, so colour pattern starts at pixel one
  wire [PIX_W-1:0] lead_pix = mode_b_q ? sens_pix_b : sens_pix_a;  // RL15
  wire [PIX_W-1:0] held_pix = mode_b_q ? sens_pix_a : sens_pix_b;  // RL9
  wire buf_we = st_q == dlr_pkg::ST_EXPOSE && sens_valid;
  wire buf_re = st_q == dlr_pkg::ST_REPLAY;

  // Held line goes to memory, not to the wire
  always_ff @(posedge clk)
  begin
    if (buf_we)
      buf_mem[{wr_bank_q, idx_q}] <= held_pix;  // RL9
  end

  // Registered read port
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_pix_q <= '0;
      rd_vld_q <= 1'b0;
      rd_last_q <= 1'b0;
    end
    else
    begin
      rd_pix_q <= buf_mem[{rd_bank_q, idx_q}];  // RL10
      rd_vld_q <= buf_re;
      rd_last_q <= buf_re && at_last;
    end
  end

  // Leading line streams straight out, replay one cycle late
  wire pk_valid = buf_we || rd_vld_q;                        // RL12
  wire [PIX_W-1:0] pk_pix = buf_we ? lead_pix : rd_pix_q;    // RL9
  wire pk_last = buf_we ? at_last : rd_last_q;
  logic line_done;

  dlr_tap_packer #(
    .PIX_W(PIX_W),
    .MAX_TAPS(MAX_TAPS)
  ) u_packer (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(pk_valid),
    .in_pix(pk_pix),
    .in_last(pk_last),
    .tap_sel(tap_q),
    .depth_sel(depth_q),
    .pix_clk(pix_clk),
    .lval(lval),
    .dval(dval),
    .video(video),
    .line_done(line_done)
  );

  // ************************************************************
  // Frame valid
  // ************************************************************
  logic [15:0] fval_cnt_q;          // Lines sent under frame valid
  wire fval_end = fval && line_done && fval_cnt_q + 16'h1 >= fval_len_q;

  // Rises only with a leading line, falls after the programmed count
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fval <= 1'b0;
      fval_cnt_q <= 16'h0;
    end
    else if (fval_len_q == 16'h0)
    begin
      fval <= 1'b0;                        // RL4
      fval_cnt_q <= 16'h0;
    end
    else if (fval_end)
    begin
      fval <= 1'b0;                        // RL3
      fval_cnt_q <= 16'h0;
    end
    else
    begin
      if (line_done && fval)
        fval_cnt_q <= fval_cnt_q + 16'h1;
      if (!fval && accept && !phase_q)
        fval <= 1'b1;                      // RL2
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  always_comb
  begin
    rdata_d = 32'h0;
    case (reg_addr)
      dlr_pkg::CTRL_ADDR:
        rdata_d = {26'h0, depth_q, tap_q, mode_b_q, en_q};
      dlr_pkg::FVLEN_ADDR:
        rdata_d = {16'h0, fval_len_q};
      dlr_pkg::LINELEN_ADDR:
        rdata_d = {18'h0, line_len_q};
      dlr_pkg::STATUS_ADDR:
        rdata_d = {fval_cnt_q, 10'h0, fval, lead_q, wr_bank_q, phase_q, st_q};
      default:
        rdata_d = 32'h0;
    endcase
  end

  // Data stand the cycle after the read strobe only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rdata_d : 32'h0;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_FVAL_ZERO: assert property (fval_len_q == 16'h0 |=> !fval)  // RL4
    else $error("frame valid high with zero length");
  AST_FVAL_EVEN: assert property (!fval_len_q[0])  // RL3
    else $error("frame valid length odd");
  AST_FVAL_DROP: assert property (fval_end |=> !fval)  // RL3
    else $error("frame valid held past its length");
  AST_FVAL_LEAD: assert property ($rose(fval) |-> lead_q && st_q == dlr_pkg::ST_EXPOSE)  // RL2
    else $error("frame valid rose on a buffered line");
  AST_EXPOSE_ODD: assert property (accept && !phase_q |=> expose_start ##1 !expose_start)  // RL8
    else $error("exposure not started on odd trigger");
  AST_NO_EXPOSE_EVEN: assert property (accept && phase_q |=> !expose_start)  // RL10
    else $error("exposure on even trigger");
  AST_REPLAY_BANK: assert property (st_q == dlr_pkg::ST_REPLAY |-> rd_bank_q != wr_bank_q)  // RL11
    else $error("replay from the freshly written bank");
  AST_MODE_B: assert property (mode_b_q |-> MODE_B_OK)  // RL7
    else $error("line B leading on wide sensor");
  AST_LINE_LEN: assert property (buf_we && at_last |=> st_q == dlr_pkg::ST_IDLE && idx_q == '0)  // RL5
    else $error("line length overrun");

  CV_EXPOSE: cover property (accept && !phase_q ##[1:1000] accept && phase_q);
  CV_FVAL_CYCLE: cover property ($rose(fval) ##[1:1000] $fell(fval));
  CV_MODE_B: cover property (mode_b_q && st_q == dlr_pkg::ST_REPLAY);

endmodule : dlr_readout

`default_nettype wire

// [rtl/dlr_tap_packer.sv]
`timescale 1ns/1ps
`default_nettype none

module dlr_tap_packer #(
  parameter int PIX_W = 12,
  parameter int MAX_TAPS = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [PIX_W-1:0] in_pix,
  input wire logic in_last,
  input wire logic [1:0] tap_sel,
  input wire logic [1:0] depth_sel,
  output logic pix_clk,
  output logic lval,
  output logic dval,
  output logic [MAX_TAPS*PIX_W-1:0] video,
  output logic line_done
);

  // ************************************************************
  // Tap gathering
  // ************************************************************
  logic [PIX_W-1:0] acc_q [MAX_TAPS];        // Pixels of the beat in work
  logic [2:0] cnt_q;                         // Next tap slot
  logic [MAX_TAPS*PIX_W-1:0] beat_w;         // Beat including this pixel
  logic [MAX_TAPS*PIX_W-1:0] hold_q;         // Completed beat awaiting edge
  logic hold_vld_q;
  logic hold_last_q;
  logic last_sent_q;                         // Final beat of line is out
  wire [3:0] taps_n = 4'h2 << tap_sel;       // RL1
  wire beat_full = in_valid && ((cnt_q == 3'(taps_n - 4'h1)) || in_last);
  wire emit = pix_clk;                       // Output moves as pix_clk falls
  logic [PIX_W-1:0] px_w;

  // Depth select keeps the upper bits, right aligned
  always_comb
  begin
    case (depth_sel)
      2'h0: px_w = {4'h0, in_pix[PIX_W-1 -: 8]};   // RL1
      2'h1: px_w = {2'h0, in_pix[PIX_W-1 -: 10]};  // RL1
      default: px_w = in_pix;
    endcase
  end

  // One slot per tap; unused taps of narrow modes read zero
  for (genvar i = 0; i < MAX_TAPS; i++)
  begin : g_tap
    wire live = 4'(i) < taps_n;
    assign beat_w[i*PIX_W +: PIX_W] = !live ? '0 :
      (in_valid && cnt_q == 3'(i)) ? px_w : acc_q[i];  // RL16

    // Slot store
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        acc_q[i] <= '0;
      else if (in_valid && cnt_q == 3'(i))
        acc_q[i] <= px_w;
    end
  end

  // Slot counter and the hand-off register; taps >= 2 means a beat
  // never completes faster than the pixel clock can carry it out, save a last beat of one pixel
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_q <= 3'h0;
      hold_vld_q <= 1'b0;
      hold_last_q <= 1'b0;
      hold_q <= '0;
    end
    else
    begin
      if (beat_full)
        cnt_q <= 3'h0;
      else if (in_valid)
        cnt_q <= cnt_q + 3'h1;
      if (beat_full)
      begin
        hold_q <= beat_w;
        hold_vld_q <= 1'b1;
        hold_last_q <= in_last;
      end
      else if (emit)
        hold_vld_q <= 1'b0;
    end
  end

  // ************************************************************
  // Camera side outputs, fixed bit places in every mode
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pix_clk <= 1'b0;
      lval <= 1'b0;
      dval <= 1'b0;
      video <= '0;
      last_sent_q <= 1'b0;
      line_done <= 1'b0;
    end
    else
    begin
      pix_clk <= !pix_clk;                   // RL6
      line_done <= 1'b0;
      if (emit && hold_vld_q)
      begin
        video <= hold_q;                     // RL16
        lval <= 1'b1;                        // RL16
        dval <= 1'b1;
        last_sent_q <= hold_last_q;
      end
      else if (emit)
      begin
        dval <= 1'b0;
        if (last_sent_q)
        begin
          lval <= 1'b0;                      // RL16
          last_sent_q <= 1'b0;
          line_done <= 1'b1;
        end
      end
    end
  end

endmodule : dlr_tap_packer

`default_nettype wire

// [verification/dlr_grabber_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Frame grabber: fires line triggers, collects video lines
// ************************************************************
module dlr_grabber_model (
  input wire logic clk,
  input wire logic fval,
  input wire logic lval,
  input wire logic dval,
  input wire logic pix_clk,
  input wire logic [dlr_pkg::MAX_TAPS*dlr_pkg::PIX_W-1:0] video,
  output logic line_trigger
);
  logic lval_q = 1'b0;        // Line valid one edge ago
  logic in_line = 1'b0;       // First beat of line seen
  logic [11:0] tap0_q = 12'h000;  // Tap 0 of first beat
  logic [11:0] tap1_q = 12'h000;  // Tap 1 of first beat
  logic fv_start_q = 1'b0;    // Frame valid at first beat
  int beats = 0;              // Beats of current or last line
  int lines = 0;              // Lines completed

  // Trigger pin idles low between pulses
  initial line_trigger = 1'b0;

  // One 48 ns trigger period; not tied to the system clock phase
  task automatic pulse();
    line_trigger = 1'b1;
    #24;
    line_trigger = 1'b0;
    #24;
  endtask : pulse

  // Beats taken on the high half of pixel clock, where data is stable
  always @(posedge clk)
  begin
    lval_q <= lval;
    if (lval_q && !lval)
    begin
      lines <= lines + 1;
      in_line <= 1'b0;
    end
    else if (pix_clk && dval)
    begin
      beats <= in_line ? beats + 1 : 1;
      if (!in_line)
      begin
        tap0_q <= video[11:0];
        tap1_q <= video[23:12];
        fv_start_q <= fval;
      end
      in_line <= 1'b1;
    end
  end

endmodule : dlr_grabber_model

`default_nettype wire

// [verification/dlr_readout_tb.sv]
`timescale 1ns/1ps
`default_nettype none

`define DLR_CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("BAD t=%0t got %h exp %h", $time, (got), (exp)); \
    end \
  end

module dlr_readout_tb;
  localparam int NPIX = 16;  // Short line keeps the run brief
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic line_trigger;
  logic sens_valid = 1'b0;
  logic [11:0] sens_pix_a = 12'h000;
  logic [11:0] sens_pix_b = 12'h000;
  logic expose_start, fval, lval, dval, pix_clk;
  logic [95:0] video;
  logic [3:0] exp_cnt = 4'h0;  // Exposures seen
  logic [4:0] sc = 5'h00;      // Sensor pixels left
  int errors = 0;
  int checked = 0;
  int fv_hits = 0;             // Cycles with frame valid high
  // Rows: {tap code, depth code, beats per line}
  logic [11:0] rows [0:5] = '{12'h008, 12'h504, 12'ha02, 12'h208, 12'h802, 12'h404};

  // ************************************************************
  // Clock, design, partner
  // ************************************************************
  always #2.5 clk = ~clk;

  dlr_readout #(.SENSOR_PIX(2048)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_trigger(line_trigger), .sens_valid(sens_valid),
    .sens_pix_a(sens_pix_a), .sens_pix_b(sens_pix_b), .expose_start(expose_start),
    .fval(fval), .lval(lval), .dval(dval), .pix_clk(pix_clk), .video(video));

  dlr_grabber_model gm_u (.clk(clk), .fval(fval), .lval(lval), .dval(dval),
    .pix_clk(pix_clk), .video(video), .line_trigger(line_trigger));

  // Sensor: position on top so even the 8 bit cut tells pixels apart
  function automatic logic [11:0] pa(input logic [3:0] e, input logic [3:0] k);
    return {k, e, 4'ha};
  endfunction : pa

  function automatic logic [11:0] pb(input logic [3:0] e, input logic [3:0] k);
    return {k, e, 4'hb};
  endfunction : pb

  // Depth cut, right aligned
  function automatic logic [11:0] cut(input logic [11:0] p, input logic [1:0] d);
    return d == 2'h0 ? {4'h0, p[11:4]} : d == 2'h1 ? {2'h0, p[11:2]} : p;
  endfunction : cut

  // Both lines read out together, never more than NPIX pixels
  always @(posedge clk)
    if (expose_start)
    begin
      exp_cnt <= exp_cnt + 4'h1;
      sc <= 5'd16;
      sens_valid <= 1'b0;
    end
    else if (sc != 5'd0)
    begin
      sens_valid <= 1'b1;
      sens_pix_a <= pa(exp_cnt, 4'(16 - sc));
      sens_pix_b <= pb(exp_cnt, 4'(16 - sc));
      sc <= sc - 5'd1;
    end
    else
      sens_valid <= 1'b0;

  always @(posedge clk)
    if (fval === 1'b1)
      fv_hits++;

  // ************************************************************
  // Bus and link tasks
  // ************************************************************
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe
  task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `DLR_CHK(reg_rdata, exp)
    @(posedge clk);
    #1;
    `DLR_CHK(reg_rdata, 32'h0)
  endtask : reg_check

  // Disable first so the next trigger exposes
  task automatic enable(input logic [31:0] c);
    reg_write(dlr_pkg::CTRL_ADDR, 32'h0);
    reg_write(dlr_pkg::CTRL_ADDR, c);
  endtask : enable

  task automatic fire_and_wait();
    int n0;
    int i;
    n0 = gm_u.lines;
    gm_u.pulse();
    for (i = 0; i < 400 && gm_u.lines == n0; i++)
      @(posedge clk);
    `DLR_CHK(gm_u.lines, n0 + 1)
    repeat (4) @(posedge clk);
  endtask : fire_and_wait

  // Six triggers, 2 taps 12 bit; leading line, then partner delayed
  task automatic run_seq(input logic mb);
    logic [3:0] e0;
    int c;
    enable({26'h0, 2'h2, 2'h0, mb, 1'b1});
    e0 = exp_cnt;
    for (c = 1; c <= 6; c++)
    begin
      fire_and_wait();
      if (c % 2 == 1)
      begin
        `DLR_CHK(gm_u.tap0_q, mb ? pb(4'(e0 + (c + 1) / 2), 0) : pa(4'(e0 + (c + 1) / 2), 0))
        `DLR_CHK(gm_u.fv_start_q, 1'b1)
      end
      else
      begin
        `DLR_CHK(fval, 1'b0)
        if (c >= 4)
          `DLR_CHK(gm_u.tap0_q, mb ? pa(4'(e0 + c / 2 - 1), 0) : pb(4'(e0 + c / 2 - 1), 0))
      end
    end
    `DLR_CHK(exp_cnt, 4'(e0 + 3))
  endtask : run_seq

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // Whole run is under a thousand cycles; this is ample headroom
  initial
  begin
    #100us;
    errors++;
    give_verdict();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    int r;
    int n;
    logic [3:0] e;
    repeat (10) @(posedge clk);
    `DLR_CHK({fval, lval, dval, pix_clk, expose_start, video}, 101'h0)
    sys_rst <= 1'b0;
    reg_check(dlr_pkg::CTRL_ADDR, 32'h0);
    reg_check(dlr_pkg::FVLEN_ADDR, 32'h0);
    reg_check(dlr_pkg::LINELEN_ADDR, 32'h0);
    reg_check(4'h2, 32'h0);
    reg_write(dlr_pkg::LINELEN_ADDR, NPIX);
    reg_write(dlr_pkg::FVLEN_ADDR, 32'h3);
    reg_check(dlr_pkg::FVLEN_ADDR, 32'h2);
    reg_check(dlr_pkg::LINELEN_ADDR, NPIX);
    // Tap and depth modes: pixel order and beat count
    for (r = 0; r < 6; r++)
    begin
      enable({26'h0, rows[r][9:8], rows[r][11:10], 2'b01});
      fire_and_wait();
      `DLR_CHK(gm_u.tap0_q, cut(pa(exp_cnt, 0), rows[r][9:8]))
      `DLR_CHK(gm_u.tap1_q, cut(pa(exp_cnt, 1), rows[r][9:8]))
      `DLR_CHK(8'(gm_u.beats), rows[r][7:0])
    end
    run_seq(1'b0);
    run_seq(1'b1);
    // Length zero keeps frame valid low
    reg_write(dlr_pkg::FVLEN_ADDR, 32'h0);
    enable(32'h1);
    n = fv_hits;
    fire_and_wait();
    fire_and_wait();
    `DLR_CHK(fv_hits, n)
    // Second trigger inside a line is dropped, phase kept
    enable(32'h1);
    n = gm_u.lines;
    e = exp_cnt;
    gm_u.pulse();
    gm_u.pulse();
    repeat (60) @(posedge clk);
    `DLR_CHK(gm_u.lines, n + 1)
    fire_and_wait();
    `DLR_CHK(exp_cnt, 4'(e + 1))
    // Disabled block ignores triggers
    reg_write(dlr_pkg::CTRL_ADDR, 32'h0);
    gm_u.pulse();
    repeat (30) @(posedge clk);
    `DLR_CHK(exp_cnt, 4'(e + 1))
    give_verdict();
  end

endmodule : dlr_readout_tb

`default_nettype wire
